// file: srcm_pkg.sv
package srcm_pkg;
  // ****************************************************************
  // register map (word offsets as byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SETPT = 8'h0C;
  localparam logic [7:0] OFS_PREREG = 8'h18;
  localparam logic [7:0] OFS_PREREG_B = 8'h1C;
  localparam int FLG_INT = 0;
  localparam int FLG_LOGIC = 1;
  localparam int FLG_IO = 2;
  localparam int FLG_EXT = 3;
  localparam int FLG_CLK = 4;
  localparam int CTL_AUX_STOP = 0;
  localparam int CTL_SPREAD_EN = 1;
  localparam int CTL_SPREAD_DEPTH = 2;
  localparam int CTL_PUMP = 3;
  localparam int CTL_LOAD = 4;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int T_VINT_US = 1000;
  localparam int T_VINT_CYC = T_VINT_US * CLK_MHZ;
  localparam int T1_US = 10;
  localparam int T1_CYC = T1_US * CLK_MHZ;
  localparam int T_EXT_NS = 2000;
  localparam int T_EXT_CYC = (T_EXT_NS * CLK_MHZ + 999) / 1000;
  localparam int T_REC_MS = 45;
  localparam int T_REC_CYC = T_REC_MS * 1000 * CLK_MHZ;
  localparam int T2_US = 20;
  localparam int T2_CYC = T2_US * CLK_MHZ;
  localparam int OSC_NOM = 140;
  localparam int OSC_TOL = 35;
  localparam int SPREAD_NARROW_KHZ = 350;
  localparam int SPREAD_WIDE_KHZ = 700;
  localparam logic [9:0] SPREAD_NARROW = 10'(SPREAD_NARROW_KHZ);
  localparam logic [9:0] SPREAD_WIDE = 10'(SPREAD_WIDE_KHZ);

  typedef enum logic [1:0] {SRCM_RUN, SRCM_FAULT, SRCM_RECOVER} srcm_state_t;

  typedef struct packed {
    logic vint_a_uv;
    logic vint_d_uv;
    logic logic_5v_uv;
    logic io_uv;
    logic pwr_ov;
    logic pwr_uv;
    logic temp_warn;
  } srcm_supply_t;

  typedef struct packed {
    logic [4:0] valve_drivers;
    logic pump_predriver;
    logic [1:0] resistive_load_driver;
  } srcm_drive_t;
endpackage : srcm_pkg

// file: srcm_supervisor.sv
`timescale 1ns/100ps
module srcm_supervisor
  import srcm_pkg::*;
#(
  parameter int FILT_CYC = T_VINT_CYC,
  parameter int REC_CYC = T_REC_CYC,
  parameter int WIN_CYC = T2_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire srcm_supply_t supply_raw,
  input wire logic aux_osc_tick,
  input wire logic [9:0] prereg_supply_a,
  input wire logic [9:0] prereg_supply_b,
  input wire logic system_reset_line_n_in,
  output logic system_reset_line_n_out,
  output logic system_reset_line_n_oe,
  output srcm_drive_t drive,
  output logic [7:0] valve_setpoint,
  output logic aux_osc_enable,
  output logic spread_enable,
  output logic [9:0] spread_deviation_khz
);
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  srcm_supply_t sup_s1_reg, sup_reg;
  logic aux_s1_reg, aux_s2_reg, aux_s3_reg;
  logic line_s1_reg, line_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sup_s1_reg <= '0;
      sup_reg <= '0;
      aux_s1_reg <= 1'b0;
      aux_s2_reg <= 1'b0;
      aux_s3_reg <= 1'b0;
      line_s1_reg <= 1'b1;
      line_reg <= 1'b1;
    end else begin
      sup_s1_reg <= supply_raw;
      sup_reg <= sup_s1_reg;
      aux_s1_reg <= aux_osc_tick;
      aux_s2_reg <= aux_s1_reg;
      aux_s3_reg <= aux_s2_reg;
      line_s1_reg <= system_reset_line_n_in;
      line_reg <= line_s1_reg;
    end
  end

  wire logic aux_edge = aux_s2_reg & ~aux_s3_reg;
  wire logic int_raw = sup_reg.vint_a_uv | sup_reg.vint_d_uv;
  // external reset only counts while we are not driving the line ourselves
  wire logic ext_raw = ~line_reg & ~system_reset_line_n_oe;

  // ****************************************************************
  // supply filters
  // ****************************************************************
  logic [23:0] int_cnt_reg, int_cnt_next;
  logic [23:0] io_cnt_reg, io_cnt_next;
  logic [23:0] ext_cnt_reg, ext_cnt_next;
  logic int_f_reg, int_f_next, io_f_reg, io_f_next, ext_f_reg, ext_f_next;
  logic lgc_f_reg, lgc_f_next;

  always_comb begin
    int_cnt_next = int_cnt_reg;
    int_f_next = int_f_reg;
    io_cnt_next = io_cnt_reg;
    io_f_next = io_f_reg;
    ext_cnt_next = ext_cnt_reg;
    ext_f_next = ext_f_reg;
    lgc_f_next = sup_reg.logic_5v_uv;
    if (int_raw == int_f_reg) begin
      int_cnt_next = '0;
    end else if (int_cnt_reg >= 24'(FILT_CYC - 1)) begin
      int_cnt_next = '0;
      int_f_next = int_raw;
    end else begin
      int_cnt_next = int_cnt_reg + 24'h1;
    end
    if (sup_reg.io_uv == io_f_reg) begin
      io_cnt_next = '0;
    end else if (io_cnt_reg >= 24'(T1_CYC - 1)) begin
      io_cnt_next = '0;
      io_f_next = sup_reg.io_uv;
    end else begin
      io_cnt_next = io_cnt_reg + 24'h1;
    end
    if (!ext_raw) begin
      ext_cnt_next = '0;
      ext_f_next = 1'b0;
    end else if (ext_cnt_reg >= 24'(T_EXT_CYC - 1)) begin
      ext_f_next = 1'b1;
    end else begin
      ext_cnt_next = ext_cnt_reg + 24'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_cnt_reg <= '0;
      io_cnt_reg <= '0;
      ext_cnt_reg <= '0;
      int_f_reg <= 1'b0;
      io_f_reg <= 1'b0;
      ext_f_reg <= 1'b0;
      lgc_f_reg <= 1'b0;
    end else begin
      int_cnt_reg <= int_cnt_next;
      io_cnt_reg <= io_cnt_next;
      ext_cnt_reg <= ext_cnt_next;
      int_f_reg <= int_f_next;
      io_f_reg <= io_f_next;
      ext_f_reg <= ext_f_next;
      lgc_f_reg <= lgc_f_next;
    end
  end

  // ****************************************************************
  // clock monitor
  // ****************************************************************
  logic [15:0] win_reg, win_next;
  logic [15:0] aux_cnt_reg, aux_cnt_next;
  logic clk_fail, mon_on;
  logic [4:0] flags_reg, flags_next;
  logic aux_stop_reg;
  srcm_state_t st_reg, st_next;

  assign mon_on = (st_reg == SRCM_RUN) & ~aux_stop_reg & ~flags_reg[FLG_CLK];

  always_comb begin
    win_next = win_reg;
    aux_cnt_next = aux_cnt_reg;
    clk_fail = 1'b0;
    if (!mon_on) begin
      win_next = '0;
      aux_cnt_next = '0;
    end else if (win_reg >= 16'(WIN_CYC - 1)) begin
      win_next = '0;
      aux_cnt_next = '0;
      clk_fail = (aux_cnt_reg < 16'(WIN_CYC * (OSC_NOM - OSC_TOL) / 1000))
               | (aux_cnt_reg > 16'(WIN_CYC * (OSC_NOM + OSC_TOL) / 1000));
    end else begin
      win_next = win_reg + 16'h1;
      aux_cnt_next = aux_cnt_reg + {15'h0, aux_edge};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_reg <= '0;
      aux_cnt_reg <= '0;
    end else begin
      win_reg <= win_next;
      aux_cnt_reg <= aux_cnt_next;
    end
  end

  // ****************************************************************
  // reset sequencer
  // ****************************************************************
  logic [23:0] rec_reg, rec_next;
  logic fault_any, clk_fault_reg, clk_fault_next;
  logic line_low_next;

  assign fault_any = int_f_reg | io_f_reg | lgc_f_reg | ext_f_reg;

  always_comb begin
    st_next = st_reg;
    rec_next = rec_reg;
    clk_fault_next = 1'b0;
    case (st_reg)
      SRCM_RUN: begin
        if (fault_any | clk_fail) begin
          st_next = SRCM_FAULT;
          clk_fault_next = clk_fail;
        end
      end
      SRCM_FAULT: begin
        rec_next = '0;
        if (!fault_any) begin
          st_next = SRCM_RECOVER;
        end
      end
      SRCM_RECOVER: begin
        if (fault_any) begin
          st_next = SRCM_FAULT;
        end else if (rec_reg >= 24'(REC_CYC - 1)) begin
          st_next = SRCM_RUN;
        end else begin
          rec_next = rec_reg + 24'h1;
        end
      end
      default: st_next = SRCM_FAULT;
    endcase
    // external reset holds line from outside; we drive for the others
    line_low_next = (st_next != SRCM_RUN) & ~ext_f_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= SRCM_FAULT;
      rec_reg <= '0;
      clk_fault_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      rec_reg <= rec_next;
      clk_fault_reg <= clk_fault_next;
    end
  end

  // ****************************************************************
  // registers and bus slave
  // ****************************************************************
  logic [7:0] ctrl_reg, ctrl_next, setpt_reg, setpt_next;
  logic [31:0] rd_reg, rd_next;
  logic wait_reg, wait_next;
  logic pwr_bad, hit_rd, hit_wr;

  assign pwr_bad = sup_reg.pwr_ov | sup_reg.pwr_uv;
  assign aux_stop_reg = ctrl_reg[CTL_AUX_STOP];
  // one wait cycle: request taken on first edge, answered on the next
  assign hit_rd = avs_read & wait_reg;
  assign hit_wr = avs_write & wait_reg;

  always_comb begin
    flags_next = flags_reg;
    ctrl_next = ctrl_reg;
    setpt_next = setpt_reg;
    rd_next = rd_reg;
    wait_next = 1'b1;
    if (avs_read | avs_write) begin
      wait_next = ~wait_reg;
    end
    if (hit_rd) begin
      case (avs_address)
        OFS_FLAGS: begin
          rd_next = {27'h0, flags_reg};
          flags_next = 5'h0;
        end
        OFS_CTRL: rd_next = {24'h0, ctrl_reg};
        OFS_STATUS: rd_next = {29'h0, sup_reg.temp_warn, pwr_bad,
                               st_reg == SRCM_RUN};
        OFS_SETPT: rd_next = {24'h0, setpt_reg};
        OFS_PREREG: rd_next = {22'h0, prereg_supply_a};
        OFS_PREREG_B: rd_next = {22'h0, prereg_supply_b};
        default: rd_next = RD_UNMAPPED;
      endcase
    end
    if (hit_wr & avs_byteenable[0]) begin
      case (avs_address)
        OFS_FLAGS: flags_next = flags_reg & ~avs_writedata[4:0];
        OFS_CTRL: ctrl_next = avs_writedata[7:0];
        OFS_SETPT: setpt_next = avs_writedata[7:0];
        default: ;
      endcase
    end
    // registers reinitialise while in reset, flags preserved
    if (st_reg != SRCM_RUN) begin
      ctrl_next = '0;
      setpt_next = '0;
    end
    if (pwr_bad) begin
      setpt_next = '0;
      ctrl_next[CTL_PUMP] = 1'b0;
    end
    // set beats clear
    if (int_f_reg) begin
      flags_next = 5'h0;
      flags_next[FLG_INT] = 1'b1;
    end else if (clk_fault_reg) begin
      flags_next = 5'h0;
      flags_next[FLG_INT] = flags_reg[FLG_INT];
      flags_next[FLG_CLK] = 1'b1;
    end
    if (io_f_reg) flags_next[FLG_IO] = 1'b1;
    if (lgc_f_reg) flags_next[FLG_LOGIC] = 1'b1;
    if (ext_f_reg) flags_next[FLG_EXT] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 5'h0;
      ctrl_reg <= '0;
      setpt_reg <= '0;
      rd_reg <= '0;
      wait_reg <= 1'b1;
    end else begin
      flags_reg <= flags_next;
      ctrl_reg <= ctrl_next;
      setpt_reg <= setpt_next;
      rd_reg <= rd_next;
      wait_reg <= wait_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  srcm_drive_t drv_next;
  logic drv_ok;

  always_comb begin
    drv_ok = st_next == SRCM_RUN;
    drv_next.valve_drivers = {5{drv_ok & ~pwr_bad}};
    drv_next.pump_predriver = drv_ok & ~pwr_bad & ctrl_next[CTL_PUMP];
    drv_next.resistive_load_driver = {2{drv_ok & ctrl_next[CTL_LOAD]}};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drive <= '0;
      valve_setpoint <= '0;
      aux_osc_enable <= 1'b0;
      spread_enable <= 1'b0;
      spread_deviation_khz <= '0;
      avs_readdata <= '0;
      avs_waitrequest <= 1'b1;
      system_reset_line_n_out <= 1'b0;
      system_reset_line_n_oe <= 1'b1;
    end else begin
      drive <= drv_next;
      valve_setpoint <= setpt_next;
      aux_osc_enable <= ~ctrl_next[CTL_AUX_STOP];
      spread_enable <= ctrl_next[CTL_SPREAD_EN];
      spread_deviation_khz <= ctrl_next[CTL_SPREAD_DEPTH] ?
                              SPREAD_WIDE : SPREAD_NARROW;
      avs_readdata <= rd_next;
      avs_waitrequest <= wait_next;
      system_reset_line_n_out <= 1'b0;
      system_reset_line_n_oe <= line_low_next;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_flag_read_clr: assert property (hit_rd && avs_address == OFS_FLAGS
    && !int_f_reg && !clk_fault_reg && !io_f_reg && !lgc_f_reg && !ext_f_reg
    |=> flags_reg == 5'h0)
    else $error("flags not cleared by read");
  a_int_flag_set: assert property (int_f_reg |=> flags_reg[FLG_INT])
    else $error("internal flag not set");
  a_clk_flag_set: assert property (clk_fail
    |=> ##1 flags_reg[FLG_CLK] && st_reg != SRCM_RUN)
    else $error("clock fail not flagged");
  a_mon_gated: assert property (st_reg != SRCM_RUN || aux_stop_reg
    || flags_reg[FLG_CLK] |=> win_reg == 16'h0 && aux_cnt_reg == 16'h0)
    else $error("monitor runs while gated");
  a_valve_pwr: assert property (pwr_bad
    |=> drive.valve_drivers == 5'h0 && valve_setpoint == 8'h0)
    else $error("valves on during power fault");
  a_fault_hold: assert property (st_reg == SRCM_FAULT && fault_any
    |=> st_reg == SRCM_FAULT)
    else $error("left fault early");
  a_drv_off_rst: assert property (st_reg != SRCM_RUN
    |=> drive == '0 || st_reg == SRCM_RUN)
    else $error("drivers on during reset");
  a_bus_wait: assert property ($rose(avs_read) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("read not answered");
endmodule : srcm_supervisor

// file: srcm_host_model.sv
`timescale 1ns/100ps
// ****************************
// host side of the reset line
// ****************************
module srcm_host_model #(
  parameter int MIN_HOLD = 400
) (
  input wire logic clk_sys,
  input wire logic dut_oe,
  input wire logic ext_go,
  input wire logic glitch_ok,
  input wire logic [15:0] ext_len,
  output logic line_n
);
  logic [15:0] hold_reg = 16'h0000;
  logic pull;
  always @(posedge clk_sys) begin
    if (ext_go) begin
      // short pulses only when a glitch is asked for
      hold_reg <= (glitch_ok || ext_len >= MIN_HOLD) ? ext_len :
        16'(MIN_HOLD);
    end else if (hold_reg != 16'h0000) begin
      hold_reg <= hold_reg - 16'h0001;
    end
  end
  assign pull = (hold_reg != 16'h0000);
  // open line with pull-up: high unless someone pulls
  assign line_n = !(dut_oe || pull);
endmodule : srcm_host_model

// file: srcm_supervisor_tb.sv
`timescale 1ns/100ps
module srcm_supervisor_tb
  import srcm_pkg::*;
;
  localparam int FILT = 20;
  localparam int REC = 50;
  localparam int WIN = 200;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  srcm_supply_t supply = '0;
  logic aux_tick = 1'b0;
  logic [9:0] pa = 10'h2A5;
  logic [9:0] pb = 10'h15A;
  logic line_n, oe, out_n, aux_en, spr_en;
  srcm_drive_t drive;
  logic [7:0] setpt;
  logic [9:0] dev;
  logic ext_go = 1'b0;
  logic glitch = 1'b0;
  logic [15:0] ext_len = 16'h0000;
  int tick_per = 7;
  int tick_cnt = 0;
  int n_fail = 0;
  int compares = 0;
  logic [31:0] rd;

  always #5 clk_sys = ~clk_sys;

  srcm_supervisor #(.FILT_CYC(FILT), .REC_CYC(REC), .WIN_CYC(WIN)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .supply_raw(supply), .aux_osc_tick(aux_tick),
    .prereg_supply_a(pa), .prereg_supply_b(pb),
    .system_reset_line_n_in(line_n), .system_reset_line_n_out(out_n),
    .system_reset_line_n_oe(oe), .drive(drive),
    .valve_setpoint(setpt), .aux_osc_enable(aux_en),
    .spread_enable(spr_en), .spread_deviation_khz(dev)
  );

  srcm_host_model i_host (
    .clk_sys(clk_sys), .dut_oe(oe), .ext_go(ext_go),
    .glitch_ok(glitch), .ext_len(ext_len), .line_n(line_n)
  );

  // aux oscillator stand-in; stands still once disabled
  always @(posedge clk_sys) begin
    if (tick_per != 0 && aux_en === 1'b1) begin
      tick_cnt <= (tick_cnt + 1 >= tick_per) ? 0 : tick_cnt + 1;
      aux_tick <= (tick_cnt < tick_per / 2);
    end
  end

  // ****************************
  // helpers
  // ****************************
  task automatic chk_word(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
    end
  endtask : chk_bit

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic bus_go(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    rd = avs_readdata;
    chk_bit("bus answer", 1'b0, avs_waitrequest);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus_go

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus_go(1'b0, a, 32'h0);
    chk_word("read data", e, rd);
  endtask : rd_chk

  task automatic wait_oe(input logic v, input int lim);
    int n;
    n = 0;
    while (oe !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk_bit("reset line drive", v, oe);
    repeat (3) @(posedge clk_sys);
  endtask : wait_oe

  task automatic quiet(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(posedge clk_sys);
      if (oe !== 1'b0) hits++;
    end
    chk_word("reset pulses", 32'h0, 32'(hits));
  endtask : quiet

  // ****************************
  // scenarios
  // ****************************
  task automatic t_supply;
    bus_go(1'b1, OFS_CTRL, 32'h8);
    supply.vint_a_uv <= 1'b1;
    supply.io_uv <= 1'b1;
    repeat (FILT / 2) @(posedge clk_sys);
    chk_bit("early reset", 1'b0, oe);
    wait_oe(1'b1, FILT + 10);
    chk_word("drive", 32'h0, 32'(drive));
    chk_bit("line out", 1'b0, out_n);
    // io filter is the fixed T1 count, so let it expire first
    repeat (T1_CYC) @(posedge clk_sys);
    supply.vint_a_uv <= 1'b0;
    repeat (FILT + REC + 20) @(posedge clk_sys);
    chk_bit("held by io", 1'b1, oe);
    supply.io_uv <= 1'b0;
    repeat (T1_CYC + REC - 5) @(posedge clk_sys);
    chk_bit("recovery", 1'b1, oe);
    wait_oe(1'b0, 30);
    rd_chk(OFS_CTRL, 32'h0);
    $display("test supply done");
  endtask : t_supply

  task automatic t_ext;
    glitch <= 1'b1;
    ext_len <= 16'h0064;
    ext_go <= 1'b1;
    @(posedge clk_sys);
    ext_go <= 1'b0;
    quiet(300);
    bus_go(1'b1, OFS_CTRL, 32'h8);
    glitch <= 1'b0;
    ext_len <= 16'h0190;
    ext_go <= 1'b1;
    @(posedge clk_sys);
    ext_go <= 1'b0;
    repeat (300) @(posedge clk_sys);
    // host holds the line, so we must not drive it ourselves
    chk_bit("ext reset drive", 1'b0, oe);
    chk_word("drive", 32'h0, 32'(drive));
    rd_chk(OFS_STATUS, 32'h0);
    wait_oe(1'b1, 200 + REC);
    wait_oe(1'b0, REC + 50);
    rd_chk(OFS_FLAGS, 32'h0D);
    rd_chk(OFS_FLAGS, 32'h0);
    rd_chk(OFS_CTRL, 32'h0);
    $display("test ext done");
  endtask : t_ext

  task automatic t_power;
    bus_go(1'b1, OFS_SETPT, 32'h5A);
    bus_go(1'b1, OFS_CTRL, 32'h8);
    chk_word("setpoint", 32'h5A, 32'(setpt));
    supply.pwr_ov <= 1'b1;
    quiet(WIN + 50);
    chk_word("drive", 32'h0, 32'(drive));
    chk_word("setpoint", 32'h0, 32'(setpt));
    rd_chk(OFS_STATUS, 32'h3);
    supply.pwr_ov <= 1'b0;
    repeat (WIN + 50) @(posedge clk_sys);
    chk_word("valves back", 32'h1F, 32'(drive.valve_drivers));
    chk_bit("pump cleared", 1'b0, drive.pump_predriver);
    $display("test power done");
  endtask : t_power

  task automatic t_clock;
    bus_go(1'b1, OFS_FLAGS, 32'h1F);
    tick_per <= 20;
    wait_oe(1'b1, 2 * WIN + 50);
    chk_word("drive", 32'h0, 32'(drive));
    wait_oe(1'b0, REC + 50);
    quiet(3 * WIN);
    rd_chk(OFS_FLAGS, 32'h10);
    wait_oe(1'b1, 2 * WIN + 50);
    tick_per <= 7;
    wait_oe(1'b0, REC + 50);
    rd_chk(OFS_FLAGS, 32'h10);
    quiet(3 * WIN);
    tick_per <= 0;
    wait_oe(1'b1, 2 * WIN + 50);
    tick_per <= 7;
    wait_oe(1'b0, REC + 50);
    rd_chk(OFS_FLAGS, 32'h10);
    $display("test clock done");
  endtask : t_clock

  task automatic t_aux;
    bus_go(1'b1, OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk_bit("aux enable", 1'b0, aux_en);
    quiet(3 * WIN);
    bus_go(1'b1, OFS_CTRL, 32'h3);
    repeat (2) @(posedge clk_sys);
    chk_bit("spread", 1'b1, spr_en);
    chk_word("deviation", 32'h15E, 32'(dev));
    bus_go(1'b1, OFS_CTRL, 32'h7);
    repeat (2) @(posedge clk_sys);
    chk_word("deviation", 32'h2BC, 32'(dev));
    bus_go(1'b1, OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk_bit("spread", 1'b0, spr_en);
    chk_bit("aux enable", 1'b1, aux_en);
    // restart of aux may or may not trip a clock reset
    repeat (3 * WIN) @(posedge clk_sys);
    wait_oe(1'b0, REC + 2 * WIN);
    bus_go(1'b1, OFS_FLAGS, 32'h1F);
    $display("test aux done");
  endtask : t_aux

  task automatic t_misc;
    supply.temp_warn <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd_chk(OFS_STATUS, 32'h5);
    bus_go(1'b1, OFS_CTRL, 32'h8);
    repeat (2) @(posedge clk_sys);
    chk_bit("pump", 1'b1, drive.pump_predriver);
    bus_go(1'b1, OFS_CTRL, 32'h18);
    repeat (2) @(posedge clk_sys);
    chk_word("load", 32'h3, 32'(drive.resistive_load_driver));
    rd_chk(OFS_PREREG, 32'h2A5);
    rd_chk(OFS_PREREG_B, 32'h15A);
    rd_chk(8'h40, RD_UNMAPPED);
    supply.temp_warn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rd_chk(OFS_STATUS, 32'h1);
    $display("test misc done");
  endtask : t_misc

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_oe(1'b0, REC + 100);
    bus_go(1'b1, OFS_FLAGS, 32'h1F);
    rd_chk(OFS_FLAGS, 32'h0);
    t_supply;
    t_ext;
    t_power;
    t_clock;
    t_aux;
    t_misc;
    end_sim;
  end

  // tests need roughly 7.5k cycles
  initial begin
    #600000;
    n_fail++;
    $display("watchdog expired");
    end_sim;
  end
endmodule : srcm_supervisor_tb
